// ---- design/iotr_dac_bank.sv ----
// Purpose: Eight DAC input registers with write and readback word formation.
// Assumes: Write strobe and clear come from logic on the same clock.
// Notes: Readback word is combinational from the stored codes.
module iotr_dac_bank (
  input wire logic clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic wr_en,
  input wire logic [iotr_pkg::CH_W-1:0] wr_ch,
  input wire logic [iotr_pkg::CODE_W-1:0] wr_code,
  input wire logic [iotr_pkg::CH_W-1:0] rd_ch,
  output logic [iotr_pkg::WORD_W-1:0] rd_word,
  output logic [iotr_pkg::PINS*iotr_pkg::CODE_W-1:0] dac_codes
);

  typedef struct packed {
    logic [iotr_pkg::PINS-1:0][iotr_pkg::CODE_W-1:0] code;
  } iotr_bank_t;

  iotr_bank_t state;
  iotr_bank_t next_state;

  always_comb begin
    next_state = state;
    if (clear) begin
      for (int i = 0; i < iotr_pkg::PINS; i++) begin
        next_state.code[i] = iotr_pkg::CODE_RESET;
      end
    end else if (wr_en) begin
      next_state.code[wr_ch] = wr_code; // [RULE5]
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // MSB flag, channel code, then stored code.
  assign rd_word = {iotr_pkg::DAC_RB_MSB, rd_ch, state.code[rd_ch]}; // [RULE6] [RULE7]
  assign dac_codes = state.code;

endmodule

// ---- design/iotr_pin_gate.sv ----
// Purpose: Per-pin output enable gating by the three-state selection.
// Assumes: Pin configuration logic supplies drive enable and level on the same clock.
// Notes: Outputs are registered, one cycle after their inputs.
module iotr_pin_gate (
  input wire logic clk,
  input wire logic reset,
  input wire logic [iotr_pkg::PINS-1:0] hiz_sel,
  input wire logic [iotr_pkg::PINS-1:0] cfg_oe,
  input wire logic [iotr_pkg::PINS-1:0] cfg_out,
  output logic [iotr_pkg::PINS-1:0] pin_oe,
  output logic [iotr_pkg::PINS-1:0] pin_out
);

  typedef struct packed {
    logic [iotr_pkg::PINS-1:0] oe;
    logic [iotr_pkg::PINS-1:0] out;
  } iotr_gate_t;

  iotr_gate_t state;
  iotr_gate_t next_state;
  logic [iotr_pkg::PINS-1:0] gated_oe;
  logic [iotr_pkg::PINS-1:0] gated_out;

  for (genvar n = 0; n < iotr_pkg::PINS; n++) begin : g_pin
    // Selected pins float; others follow their configured function.
    assign gated_oe[n] = hiz_sel[n] ? 1'b0 : cfg_oe[n]; // [RULE2] [RULE3]
    assign gated_out[n] = hiz_sel[n] ? 1'b0 : cfg_out[n]; // [RULE2] [RULE3]
  end

  always_comb begin
    next_state = state;
    next_state.oe = gated_oe;
    next_state.out = gated_out;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pin_oe = state.oe;
  assign pin_out = state.out;

endmodule

// ---- design/iotr_pkg.sv ----
// Purpose: Constants for the pin three-state, keyed reset and readback register bank.
// Assumes: One 50 MHz clock; registers reached through a pointer/data register port.
// Notes: All offsets, fields and codes used by the bank live here.
// Function
// RULE1 - Three-state register holds one bit per pin 0..7; upper byte reserved.
// RULE2 - Bit 0 leaves the pin to its separate pin configuration settings.
// RULE3 - Bit 1 forces the pin to high impedance, overriding its function.
// RULE4 - Writing key 10110101100 to low eleven reset bits fully resets device.
// RULE5 - DAC write takes 12-bit code bits 11..0 into addressed channel; 15..12 reserved.
// RULE6 - Every DAC readback word has its most significant bit set.
// RULE7 - DAC readback carries 3-bit channel code then the 12-bit input register value.
// RULE8 - ADC result has bit 15 clear, channel in 14..12, result in 11..0.
// RULE9 - Temperature word carries tag 0x8 in 15..12 and value in 11..0.
// RULE10 - A reset register write with any other value changes nothing.
package iotr_pkg;

  // ********************************
  // Widths
  // ********************************
  localparam int PINS = 8;
  localparam int CH_W = 3;
  localparam int CODE_W = 12;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 8;

  // ********************************
  // Register pointer values
  // ********************************
  localparam logic [ADDR_W-1:0] ADDR_TRISTATE = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_SOFTWARE_RESET_KEY = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_DAC_WR_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_DAC_RD_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_ADC_RESULT = 8'h30;
  localparam logic [ADDR_W-1:0] ADDR_TEMP_RESULT = 8'h31;

  // ********************************
  // Field values
  // ********************************
  localparam logic [10:0] RESET_KEY = 11'h5ac;
  localparam logic [10:0] RESET_KEY_MASK = 11'h7ff;
  localparam logic [0:0] DAC_RB_MSB = 1'h1;
  localparam logic [0:0] ADC_RB_MSB = 1'h0;
  localparam logic [3:0] TEMP_TAG = 4'h8;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [PINS-1:0] TRISTATE_RESET = 8'h00;
  localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;

endpackage

// ---- design/iotr_regs.sv ----
// Purpose: Top of the three-state, keyed reset, DAC write and readback register bank.
// Assumes: Serial framing decodes each access into a one-cycle strobe with pointer and data.
// Notes: Converter results arrive as one-cycle strobes from logic on the same clock.
module iotr_regs (
  input wire logic clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [iotr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [iotr_pkg::WORD_W-1:0] reg_wdata,
  output logic [iotr_pkg::WORD_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic adc_done,
  input wire logic [iotr_pkg::CH_W-1:0] adc_channel,
  input wire logic [iotr_pkg::CODE_W-1:0] adc_data,
  input wire logic temp_done,
  input wire logic [iotr_pkg::CODE_W-1:0] temp_data,
  input wire logic [iotr_pkg::PINS-1:0] cfg_oe,
  input wire logic [iotr_pkg::PINS-1:0] cfg_out,
  output logic [iotr_pkg::PINS-1:0] pin_oe,
  output logic [iotr_pkg::PINS-1:0] pin_out,
  output logic [iotr_pkg::PINS*iotr_pkg::CODE_W-1:0] dac_codes,
  output logic device_reset
);

  // ********************************
  // State
  // ********************************
  typedef struct packed {
    logic [iotr_pkg::PINS-1:0] pin_tristate_select;
    logic [iotr_pkg::WORD_W-1:0] conversion_result_word;
    logic [iotr_pkg::WORD_W-1:0] temperature_result_word;
    logic [iotr_pkg::WORD_W-1:0] rdata;
    logic rvalid;
    logic soft_reset;
  } iotr_state_t;

  iotr_state_t state;
  iotr_state_t next_state;

  // ********************************
  // Decode
  // ********************************
  logic key_hit;
  logic dac_wr_hit;
  logic dac_rd_hit;
  logic [iotr_pkg::WORD_W-1:0] dac_rd_word;

  always_comb begin
    key_hit = 1'b0;
    dac_wr_hit = 1'b0;
    dac_rd_hit = 1'b0;
    if (reg_addr == iotr_pkg::ADDR_SOFTWARE_RESET_KEY) begin
      // Only the exact key in the low eleven bits counts; upper bits are ignored.
      key_hit = (reg_wdata[10:0] & iotr_pkg::RESET_KEY_MASK) == iotr_pkg::RESET_KEY; // [RULE4] [RULE10]
    end else if (reg_addr[iotr_pkg::ADDR_W-1:iotr_pkg::CH_W] ==
                 iotr_pkg::ADDR_DAC_WR_BASE[iotr_pkg::ADDR_W-1:iotr_pkg::CH_W]) begin
      dac_wr_hit = 1'b1;
    end else if (reg_addr[iotr_pkg::ADDR_W-1:iotr_pkg::CH_W] ==
                 iotr_pkg::ADDR_DAC_RD_BASE[iotr_pkg::ADDR_W-1:iotr_pkg::CH_W]) begin
      dac_rd_hit = 1'b1;
    end
  end

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    next_state = state;
    next_state.rvalid = 1'b0;
    next_state.soft_reset = 1'b0;
    if (state.soft_reset) begin
      // Full reset clears every writable register and stored result.
      next_state.pin_tristate_select = iotr_pkg::TRISTATE_RESET; // [RULE4]
      next_state.conversion_result_word = iotr_pkg::WORD_ZERO;
      next_state.temperature_result_word = iotr_pkg::WORD_ZERO;
      next_state.rdata = iotr_pkg::WORD_ZERO;
    end else begin
      if (reg_wr) begin
        if (reg_addr == iotr_pkg::ADDR_TRISTATE) begin
          // Upper byte is reserved and not stored.
          next_state.pin_tristate_select = reg_wdata[iotr_pkg::PINS-1:0]; // [RULE1]
        end else if (reg_addr == iotr_pkg::ADDR_SOFTWARE_RESET_KEY) begin
          next_state.soft_reset = key_hit; // [RULE4] [RULE10]
        end
      end
      if (adc_done) begin
        next_state.conversion_result_word = {iotr_pkg::ADC_RB_MSB, adc_channel, adc_data}; // [RULE8]
      end
      if (temp_done) begin
        next_state.temperature_result_word = {iotr_pkg::TEMP_TAG, temp_data}; // [RULE9]
      end
      if (reg_rd) begin
        next_state.rvalid = 1'b1;
        if (reg_addr == iotr_pkg::ADDR_TRISTATE) begin
          next_state.rdata = {{(iotr_pkg::WORD_W-iotr_pkg::PINS){1'b0}}, state.pin_tristate_select}; // [RULE1]
        end else if (dac_rd_hit) begin
          next_state.rdata = dac_rd_word; // [RULE6] [RULE7]
        end else if (reg_addr == iotr_pkg::ADDR_ADC_RESULT) begin
          next_state.rdata = state.conversion_result_word; // [RULE8]
        end else if (reg_addr == iotr_pkg::ADDR_TEMP_RESULT) begin
          next_state.rdata = state.temperature_result_word; // [RULE9]
        end else begin
          // Reset, DAC write and unmapped pointers read as zero.
          next_state.rdata = iotr_pkg::WORD_ZERO;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ********************************
  // Submodules
  // ********************************
  iotr_dac_bank u_dac_bank (
    .clk(clk),
    .reset(reset),
    .clear(state.soft_reset),
    .wr_en(reg_wr & dac_wr_hit & ~state.soft_reset),
    .wr_ch(reg_addr[iotr_pkg::CH_W-1:0]),
    .wr_code(reg_wdata[iotr_pkg::CODE_W-1:0]),
    .rd_ch(reg_addr[iotr_pkg::CH_W-1:0]),
    .rd_word(dac_rd_word),
    .dac_codes(dac_codes)
  );

  iotr_pin_gate u_pin_gate (
    .clk(clk),
    .reset(reset),
    .hiz_sel(state.pin_tristate_select),
    .cfg_oe(cfg_oe),
    .cfg_out(cfg_out),
    .pin_oe(pin_oe),
    .pin_out(pin_out)
  );

  // ********************************
  // Outputs
  // ********************************
  assign reg_rdata = state.rdata;
  assign reg_rvalid = state.rvalid;
  assign device_reset = state.soft_reset;

endmodule

// ---- sim/iotr_host.sv ----
// Purpose: Host side model issuing register accesses.
// Assumes: One strobe cycle per access.
// Notes: Released lines show inverted values.
module iotr_host (
  input wire logic clk,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [7:0] reg_addr = 8'h00,
  output logic [15:0] reg_wdata = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ns;
  // Performs one access; a read also waits for read data.
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q, output bit ok);
    ok = w;
    q = 16'h0000;
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge clk);
      ok = reg_rvalid === 1'b1;
      q = reg_rdata;
    end
  endtask
endmodule

// ---- sim/iotr_regs_asserts.sv ----
// Purpose: Port checker for the register bank.
// Assumes: One clock, async reset.
// Notes: Shadows the three-state bits.
module iotr_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [7:0] cfg_oe,
  input wire logic [7:0] cfg_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_out,
  input wire logic [95:0] dac_codes,
  input wire logic device_reset
);
  logic [7:0] hiz;
  logic [7:0] ra;
  logic [1:0] up;
  wire key_wr = reg_wr && reg_addr == 8'h02 && reg_wdata[10:0] == 11'h5ac && !device_reset;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hiz <= 8'h00;
      ra <= 8'h00;
      up <= 2'h0;
    end else begin
      up <= {up[0], 1'b1};
      if (reg_rd) ra <= reg_addr;
      if (device_reset) hiz <= 8'h00;
      else if (reg_wr && reg_addr == 8'h01) hiz <= reg_wdata[7:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_key; key_wr; endsequence
  sequence s_clr; device_reset ##1 (!device_reset && dac_codes == 96'h0 && reg_rdata == 16'h0000); endsequence
  property p_pin; up[1] |-> pin_oe == ($past(cfg_oe) & ~$past(hiz)) && pin_out == ($past(cfg_out) & ~$past(hiz));
  endproperty
  property p_ts; reg_rvalid && ra == 8'h01 |-> reg_rdata == {8'h00, $past(hiz)}; endproperty
  property p_drb; reg_rvalid && ra[7:3] == 5'h04 |-> reg_rdata[15:12] == {1'b1, ra[2:0]}; endproperty
  property p_adc; reg_rvalid && ra == 8'h30 |-> !reg_rdata[15]; endproperty
  property p_tmp; reg_rvalid && ra == 8'h31 |-> reg_rdata[15:12] == 4'h8; endproperty
  property p_dwr; reg_wr && reg_addr[7:3] == 5'h02 && !device_reset
    |=> dac_codes[$past(reg_addr[2:0]) * 12 +: 12] == $past(reg_wdata[11:0]); endproperty
  property p_key; s_key |=> s_clr; endproperty
  property p_nokey; device_reset |-> $past(key_wr); endproperty
  a_pin: assert property (p_pin) else $error("pin gating wrong");
  a_ts: assert property (p_ts) else $error("three-state readback wrong");
  a_drb: assert property (p_drb) else $error("dac readback header wrong");
  a_adc: assert property (p_adc) else $error("adc word top bit set");
  a_tmp: assert property (p_tmp) else $error("temperature tag wrong");
  a_dwr: assert property (p_dwr) else $error("dac code not loaded");
  a_key: assert property (p_key) else $error("keyed reset missing");
  a_nokey: assert property (p_nokey) else $error("reset without key");
endmodule
bind iotr_regs iotr_chk u_chk (.*);

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the register bank.
// Assumes: Host model issues the accesses.
// Notes: Expected words built from the field layout.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset, reg_wr, reg_rd, reg_rvalid, adc_done, temp_done, device_reset;
  logic [7:0] reg_addr, cfg_oe, cfg_out, pin_oe, pin_out;
  logic [15:0] reg_wdata, reg_rdata;
  logic [2:0] adc_channel;
  logic [11:0] adc_data, temp_data;
  logic [95:0] dac_codes;
  int err_total = 0;
  int n_compared = 0;
  iotr_regs u_dut (.*);
  iotr_host u_host (.*);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic cmp(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    bit ok;
    u_host.acc(1'b1, a, d, q, ok);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] q;
    bit ok;
    u_host.acc(1'b0, a, 16'h0000, q, ok);
    if (!ok) begin
      err_total++;
      close_out();
    end else begin
      cmp($sformatf("read %h", a), q, e);
    end
  endtask
  initial begin
    reset = 1'b1;
    {adc_done, temp_done, adc_channel, adc_data, temp_data} = '0;
    cfg_oe = 8'hff;
    cfg_out = 8'h3c;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd(8'h01, 16'h0000);
    wr(8'h01, 16'hff5a);
    rd(8'h01, 16'h005a);
    cmp("pin_oe", {8'h00, pin_oe}, 16'h00a5);
    cmp("pin_out", {8'h00, pin_out}, 16'h0024);
    for (int c = 0; c < 8; c++) begin
      wr(8'h10 + c[7:0], {4'hf, 12'h111 * c[11:0]});
      rd(8'h20 + c[7:0], {1'b1, c[2:0], 12'h111 * c[11:0]});
      cmp("dac code", {4'h0, dac_codes[c * 12 +: 12]}, {4'h0, 12'h111 * c[11:0]});
    end
    @(posedge clk);
    {adc_done, adc_channel, adc_data, temp_done, temp_data} <= {1'b1, 3'h5, 12'h123, 1'b1, 12'habc};
    @(posedge clk);
    {adc_done, temp_done} <= 2'h0;
    rd(8'h30, 16'h5123);
    rd(8'h31, 16'h8abc);
    wr(8'h02, 16'h05ad);
    rd(8'h01, 16'h005a);
    wr(8'h02, 16'hf5ac);
    rd(8'h01, 16'h0000);
    rd(8'h23, 16'hb000);
    cmp("dac code7", {4'h0, dac_codes[95:84]}, 16'h0000);
    cmp("pin_out", {8'h00, pin_out}, 16'h003c);
    rd(8'h02, 16'h0000);
    rd(8'h17, 16'h0000);
    cmp("pin_oe", {8'h00, pin_oe}, 16'h00ff);
    close_out();
  end
endmodule
